// ---- hdl/pscs_cache.sv ----
`timescale 1ns/1ps
`include "pscs_consts.svh"
// Function
// - 32 Kbyte instruction cache, always a subset of the secondary cache.
// - instruction lines of 16 words, two ways, least-recently-used victim.
// - instruction set from virtual bits, tag compared with physical address.
// - instruction line is either invalid or valid.
// - instruction state changes only on fill, subset, maintenance, external invalidations.
// - 32 Kbyte data cache, 8-word lines, two ways, LRU, subset of secondary.
// - stores write the cached line; modified lines leave later.
// - dirty data lines go to secondary before secondary writes them out.
// - data set from virtual bits, tag compared with physical address.
// - data line is invalid, clean exclusive, dirty exclusive or shared.
// - per-line inconsistent flag marks data differing from secondary.
// - valid data line state always equals the secondary line state.
// - data state changes only on miss, write hit, subset, maintenance, external requests.
// - line accessed by a queue entry is locked until it graduates.
// - later entries on the same line share the lock.
// - original mode: other way of locked set only for oldest entry.
// - relaxed mode: second way for oldest entry holding no lock.
// - write-invalidate coherency, device acts on external coherency requests.
module pscs_cache import pscs_pkg::*; (
  input  wire logic                     clk_sys,         // core clock, 125 MHz
  input  wire logic                     rst_b,           // sync reset, low active
  input  wire logic                     ce,              // clock enable, freezes all state
  input  wire logic                     req_valid,       // request present
  input  wire pscs_req_t                req,             // request fields
  output logic                          req_ready,       // request accepted this cycle
  output logic                          rsp_valid,       // answer, one cycle after take
  output pscs_rsp_t                     rsp,             // answer fields
  output pscs_wb_t                      wb,              // write-back to secondary
  input  wire logic                     lock_relaxed,    // second-way lock policy
  input  wire logic                     aq_alloc_valid,  // address_queue entry enters
  input  wire logic [`PSCS_AQ_ID_W-1:0] aq_alloc_entry,  // its id
  input  wire logic                     aq_grad_valid,   // address_queue entry graduates
  input  wire logic [`PSCS_AQ_ID_W-1:0] aq_grad_entry    // its id
);
  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic f_match(input logic vld, input logic [`PSCS_TAG_W-1:0] a,
                                   input logic [`PSCS_TAG_W-1:0] b);
    f_match = vld && (a == b);
  endfunction

  // ****************************************************************
  // arrays
  // ****************************************************************
  // instruction tag store, two ways of 256 sets of 64 bytes
  logic [`PSCS_TAG_W-1:0] itag_q [`PSCS_WAYS][`PSCS_ISETS];
  logic                   ival_q [`PSCS_WAYS][`PSCS_ISETS];
  logic                   ilru_q [`PSCS_ISETS];
  // data tag store, two ways of 512 sets of 32 bytes
  logic [`PSCS_TAG_W-1:0] dtag_q [`PSCS_WAYS][`PSCS_DSETS];
  pscs_dstate_t           dst_q  [`PSCS_WAYS][`PSCS_DSETS];
  logic                   dinc_q [`PSCS_WAYS][`PSCS_DSETS];
  logic                   dlru_q [`PSCS_DSETS];

  pscs_mode_t             mode_q;
  logic [`PSCS_DSET_W-1:0] sweep_q;
  logic                   rsp_valid_q;
  pscs_rsp_t              rsp_q;
  pscs_wb_t               wb_q;

  // ****************************************************************
  // lookup decode
  // ****************************************************************
  // instruction set from virtual bits
  wire logic [`PSCS_ISET_W-1:0] iset = req.vidx[`PSCS_VIDX_W-1:`PSCS_IOFF_W];
  wire logic [`PSCS_DSET_W-1:0] dset = req.vidx[`PSCS_VIDX_W-1:`PSCS_DOFF_W];
  wire logic [1:0] ihit = {f_match(ival_q[1][iset], itag_q[1][iset], req.ptag),
                           f_match(ival_q[0][iset], itag_q[0][iset], req.ptag)};
  // physical tag compare on any non-invalid line
  wire logic [1:0] dhit = {f_match(dst_q[1][dset] != PSCS_INV, dtag_q[1][dset], req.ptag),
                           f_match(dst_q[0][dset] != PSCS_INV, dtag_q[0][dset], req.ptag)};
  wire logic       iway = ihit[1];
  wire logic       dway = dhit[1];
  wire pscs_dstate_t dcur = dst_q[dway][dset];
  wire logic       dcur_inc = dinc_q[dway][dset];

  wire logic [1:0] locked;
  wire logic       lock_grant;
  // every load or store hit asks for the line lock; kept out of the decode process so no loop runs through it
  wire logic       lock_req = (req.op == PSCS_OP_DLOAD || req.op == PSCS_OP_DSTORE) && (|dhit);
  // data fill avoids a locked victim
  wire logic       vway = locked[dlru_q[dset]] ? ~dlru_q[dset] : dlru_q[dset];
  wire logic       take = req_valid && req_ready && ce;

  assign req_ready = (mode_q == PSCS_RUN);

  // ****************************************************************
  // operation decode
  // ****************************************************************
  logic         i_wr, i_wr_way, i_wr_val, i_wr_tag, i_lru_wr, i_lru_val;
  logic         d_wr, d_wr_way, d_wr_inc, d_wr_tag, d_lru_wr, d_lru_val;
  pscs_dstate_t d_wr_st;
  pscs_rsp_t    rsp_d;
  pscs_wb_t     wb_d;

  // one request fully decided per cycle; arrays are read combinationally
  always_comb begin
    i_wr = 1'b0; i_wr_way = 1'b0; i_wr_val = 1'b0; i_wr_tag = 1'b0;
    i_lru_wr = 1'b0; i_lru_val = 1'b0;
    d_wr = 1'b0; d_wr_way = dway; d_wr_st = PSCS_INV; d_wr_inc = 1'b0; d_wr_tag = 1'b0;
    d_lru_wr = 1'b0; d_lru_val = 1'b0;
    rsp_d = '0;
    wb_d = '0;
    wb_d.set = dset;
    wb_d.way = dway;
    wb_d.tag = dtag_q[dway][dset];
    unique case (req.op)
      PSCS_OP_IFETCH: begin
        rsp_d.hit = |ihit;
        rsp_d.way = iway;
        // hit steers replacement bit to the other way
        i_lru_wr  = |ihit;
        i_lru_val = ~iway;
      end
      // fetch-miss fill into the LRU way
      // fill is the only way an instruction line becomes valid
      PSCS_OP_IFILL: begin
        i_wr = 1'b1; i_wr_way = ilru_q[iset]; i_wr_val = 1'b1; i_wr_tag = 1'b1;
        i_lru_wr = 1'b1; i_lru_val = ~ilru_q[iset];
        rsp_d.way = ilru_q[iset];
      end
      PSCS_OP_DLOAD, PSCS_OP_DSTORE: begin
        rsp_d.hit = |dhit;
        rsp_d.way = dway;
        rsp_d.state = dcur;
        rsp_d.inconsistent = dcur_inc;
        // a refused lock stalls the access for a retry
        rsp_d.stall = (|dhit) && !lock_grant;
        d_lru_wr = (|dhit) && lock_grant;
        d_lru_val = ~dway;
        if (req.op == PSCS_OP_DSTORE && (|dhit) && lock_grant) begin
          // store writes the line and leaves memory for later
          // write hit to clean exclusive becomes dirty exclusive
          // store to a non-shared line makes it differ from the secondary copy
          rsp_d.upgrade = (dcur == PSCS_SHD);
          d_wr = (dcur != PSCS_SHD);
          d_wr_st = PSCS_DEX;
          d_wr_inc = 1'b1;
        end
      end
      PSCS_OP_DFILL: begin
        // miss fill into the LRU way, or the other way if the LRU way is locked; stalls if both ways are locked
        rsp_d.stall = &locked;
        rsp_d.way = vway;
        wb_d.way = vway;
        wb_d.tag = dtag_q[vway][dset];
        // a dirty victim goes to the secondary cache first
        wb_d.valid = !(&locked) && dinc_q[vway][dset] && dst_q[vway][dset] != PSCS_INV;
        d_wr = !(&locked); d_wr_way = vway; d_wr_tag = 1'b1;
        // the secondary supplies the new state
        d_wr_st = req.state;
        d_lru_wr = !(&locked); d_lru_val = ~vway;
      end
      PSCS_OP_DUPGRADE: begin
        // secondary state copied after an upgrade completes
        rsp_d.hit = |dhit;
        d_wr = |dhit; d_wr_st = req.state; d_wr_inc = dcur_inc;
      end
      PSCS_OP_EXT_SHR: begin
        // shared intervention keeps the line, demoted to shared
        rsp_d.hit = |dhit;
        wb_d.valid = (|dhit) && dcur_inc;
        d_wr = |dhit; d_wr_st = PSCS_SHD;
      end
      PSCS_OP_EXT_EXC, PSCS_OP_EXT_INV: begin
        // write-invalidate, both caches drop the line
        // external exclusive and invalidate clear the instruction line
        rsp_d.hit = (|dhit) || (|ihit);
        i_wr = |ihit; i_wr_way = iway;
        // intervention data passes through the secondary first
        wb_d.valid = (req.op == PSCS_OP_EXT_EXC) && (|dhit) && dcur_inc;
        d_wr = |dhit; d_wr_st = PSCS_INV;
      end
      PSCS_OP_SUBSET_I: begin
        // subset enforcement when the secondary drops a line
        rsp_d.hit = |ihit;
        i_wr = |ihit; i_wr_way = iway;
      end
      PSCS_OP_SUBSET_D: begin
        // inconsistent data written back before the secondary evicts
        rsp_d.hit = |dhit;
        wb_d.valid = (|dhit) && dcur_inc;
        d_wr = |dhit; d_wr_st = PSCS_INV;
      end
      PSCS_OP_CACHE_II: begin
        i_wr = 1'b1; i_wr_way = req.way;
      end
      PSCS_OP_CACHE_DW: begin
        // index write-back invalidate on the named way
        wb_d.way = req.way;
        wb_d.tag = dtag_q[req.way][dset];
        wb_d.valid = dinc_q[req.way][dset] && dst_q[req.way][dset] != PSCS_INV;
        d_wr = 1'b1; d_wr_way = req.way; d_wr_st = PSCS_INV;
      end
      default: begin
        rsp_d = '0;
      end
    endcase
  end

  // ****************************************************************
  // locks
  // ****************************************************************
  pscs_lock #(
    .DEPTH (`PSCS_AQ_DEPTH),
    .ID_W  (`PSCS_AQ_ID_W),
    .SET_W (`PSCS_DSET_W)
  ) u_lock (
    .clk_sys     (clk_sys),
    .rst_b       (rst_b),
    .ce          (ce),
    .relaxed     (lock_relaxed),
    .alloc_valid (aq_alloc_valid),
    .alloc_entry (aq_alloc_entry),
    .grad_valid  (aq_grad_valid),
    .grad_entry  (aq_grad_entry),
    .acq_valid   (take && lock_req),
    .acq_entry   (req.aq_entry),
    .acq_set     (dset),
    .acq_way     (dway),
    .acq_grant   (lock_grant),
    .qry_set     (dset),
    .qry_locked  (locked)
  );

  // ****************************************************************
  // control and answer
  // ****************************************************************
  // sweep clears all line states after reset; requests wait for it
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      mode_q  <= PSCS_SWEEP;
      sweep_q <= '0;
    end else if (ce && mode_q == PSCS_SWEEP) begin
      sweep_q <= sweep_q + 1'b1;
      if (&sweep_q) begin
        mode_q <= PSCS_RUN;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rsp_valid_q <= 1'b0;
      rsp_q       <= '0;
      wb_q        <= '0;
    end else if (ce) begin
      rsp_valid_q <= take;
      rsp_q       <= take ? rsp_d : rsp_q;
      wb_q.valid  <= take && wb_d.valid;
      wb_q.way    <= take ? wb_d.way : wb_q.way;
      wb_q.set    <= take ? wb_d.set : wb_q.set;
      wb_q.tag    <= take ? wb_d.tag : wb_q.tag;
    end
  end

  assign rsp_valid = rsp_valid_q;
  assign rsp       = rsp_q;
  assign wb        = wb_q;

  // ****************************************************************
  // array writes
  // ****************************************************************
  // instruction lines hold only a valid bit
  always_ff @(posedge clk_sys) begin
    if (ce) begin
      if (mode_q == PSCS_SWEEP) begin
        ival_q[0][sweep_q[`PSCS_ISET_W-1:0]] <= 1'b0;
        ival_q[1][sweep_q[`PSCS_ISET_W-1:0]] <= 1'b0;
        ilru_q[sweep_q[`PSCS_ISET_W-1:0]]    <= 1'b0;
      end else if (take) begin
        if (i_wr) begin
          ival_q[i_wr_way][iset] <= i_wr_val;
        end
        if (i_wr && i_wr_tag) begin
          itag_q[i_wr_way][iset] <= req.ptag;
        end
        if (i_lru_wr) begin
          ilru_q[iset] <= i_lru_val;
        end
      end
    end
  end

  // four-state data line plus separate inconsistent flag
  always_ff @(posedge clk_sys) begin
    if (ce) begin
      if (mode_q == PSCS_SWEEP) begin
        dst_q[0][sweep_q]  <= PSCS_INV;
        dst_q[1][sweep_q]  <= PSCS_INV;
        dinc_q[0][sweep_q] <= 1'b0;
        dinc_q[1][sweep_q] <= 1'b0;
        dlru_q[sweep_q]    <= 1'b0;
      end else if (take) begin
        if (d_wr) begin
          dst_q[d_wr_way][dset]  <= d_wr_st;
          dinc_q[d_wr_way][dset] <= d_wr_inc;
        end
        if (d_wr && d_wr_tag) begin
          dtag_q[d_wr_way][dset] <= req.ptag;
        end
        if (d_lru_wr) begin
          dlru_q[dset] <= d_lru_val;
        end
      end
    end
  end
endmodule

// ---- hdl/pscs_consts.svh ----
`ifndef PSCS_CONSTS_SVH
`define PSCS_CONSTS_SVH

// ****************************************************************
// cache geometry
// ****************************************************************
`define PSCS_CACHE_BYTES  32768
`define PSCS_WORD_BYTES   4
`define PSCS_ILINE_WORDS  16
`define PSCS_DLINE_WORDS  8
`define PSCS_WAYS         2
`define PSCS_ISETS        256
`define PSCS_DSETS        512
`define PSCS_ISET_W       8
`define PSCS_DSET_W       9
`define PSCS_IOFF_W       6
`define PSCS_DOFF_W       5

// ****************************************************************
// addressing
// ****************************************************************
`define PSCS_VIDX_W       14
`define PSCS_TAG_W        28
`define PSCS_AQ_DEPTH     16
`define PSCS_AQ_ID_W      4

`endif

// ---- hdl/pscs_lock.sv ----
`timescale 1ns/1ps
`include "pscs_consts.svh"
// ****************************************************************
// address_queue line locks for the data cache
// ****************************************************************
module pscs_lock import pscs_pkg::*; #(
  parameter int DEPTH = `PSCS_AQ_DEPTH,
  parameter int ID_W  = `PSCS_AQ_ID_W,
  parameter int SET_W = `PSCS_DSET_W
) (
  input  wire logic             clk_sys,      // core clock
  input  wire logic             rst_b,        // sync reset, low active
  input  wire logic             ce,           // clock enable
  input  wire logic             relaxed,      // relaxed second-way grant
  input  wire logic             alloc_valid,  // entry enters queue
  input  wire logic [ID_W-1:0]  alloc_entry,  // entering entry id
  input  wire logic             grad_valid,   // entry graduates
  input  wire logic [ID_W-1:0]  grad_entry,   // graduating entry id
  input  wire logic             acq_valid,    // lock request
  input  wire logic [ID_W-1:0]  acq_entry,    // requesting entry
  input  wire logic [SET_W-1:0] acq_set,      // requested set
  input  wire logic             acq_way,      // requested way
  output logic                  acq_grant,    // lock granted
  input  wire logic [SET_W-1:0] qry_set,      // replacement query set
  output logic [1:0]            qry_locked    // ways locked in qry_set
);
  logic [DEPTH-1:0] live_q;
  logic [DEPTH-1:0] held_q;
  logic [SET_W-1:0] set_q [DEPTH];
  logic             way_q [DEPTH];
  // older_q[i][j]: entry j entered the queue before entry i
  logic [DEPTH-1:0] older_q [DEPTH];
  logic [DEPTH-1:0] same_line;
  logic [DEPTH-1:0] other_way;
  logic [DEPTH-1:0] q_way0;
  logic [DEPTH-1:0] q_way1;

  // per-entry match vectors against request and query
  always_comb begin
    for (int k = 0; k < DEPTH; k++) begin
      same_line[k] = held_q[k] && set_q[k] == acq_set && way_q[k] == acq_way;
      other_way[k] = held_q[k] && set_q[k] == acq_set && way_q[k] != acq_way;
      q_way0[k]    = held_q[k] && set_q[k] == qry_set && !way_q[k];
      q_way1[k]    = held_q[k] && set_q[k] == qry_set && way_q[k];
    end
  end

  wire logic oldest_live = ~|(older_q[acq_entry] & live_q);
  wire logic oldest_free = ~|(older_q[acq_entry] & live_q & ~held_q) && !held_q[acq_entry];
  // original variant, only oldest entry takes the other way
  // relaxed variant, oldest entry without a lock
  wire logic deadlock_ok = relaxed ? oldest_free : oldest_live;
  // joining an existing lock on the same line
  assign acq_grant  = acq_valid && live_q[acq_entry] && (|same_line || !(|other_way) || deadlock_ok);
  assign qry_locked = {|q_way1, |q_way0};

  // lock held from grant until graduation
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      live_q <= '0;
      held_q <= '0;
    end else if (ce) begin
      if (alloc_valid) begin
        live_q[alloc_entry] <= 1'b1;
        held_q[alloc_entry] <= 1'b0;
      end
      if (acq_grant) begin
        held_q[acq_entry] <= 1'b1;
      end
      if (grad_valid) begin
        live_q[grad_entry] <= 1'b0;
        held_q[grad_entry] <= 1'b0;
      end
    end
  end

  // lock location and age matrix carry no control meaning while dead
  always_ff @(posedge clk_sys) begin
    if (ce) begin
      if (acq_grant) begin
        set_q[acq_entry] <= acq_set;
        way_q[acq_entry] <= acq_way;
      end
      if (alloc_valid) begin
        older_q[alloc_entry] <= live_q;
      end
      if (grad_valid) begin
        for (int k = 0; k < DEPTH; k++) begin
          older_q[k][grad_entry] <= 1'b0;
        end
      end
    end
  end
endmodule

// ---- hdl/pscs_pkg.sv ----
package pscs_pkg;
  `include "pscs_consts.svh"

  // data cache line state, shared with the secondary cache
  typedef enum logic [1:0] {
    PSCS_INV = 2'b00,
    PSCS_CEX = 2'b01,
    PSCS_DEX = 2'b10,
    PSCS_SHD = 2'b11
  } pscs_dstate_t;

  // request opcodes from pipeline, secondary controller and coherency
  typedef enum logic [3:0] {
    PSCS_OP_NOP      = 4'b0000,
    PSCS_OP_IFETCH   = 4'b0001,
    PSCS_OP_IFILL    = 4'b0010,
    PSCS_OP_DLOAD    = 4'b0011,
    PSCS_OP_DSTORE   = 4'b0100,
    PSCS_OP_DFILL    = 4'b0101,
    PSCS_OP_EXT_SHR  = 4'b0110,
    PSCS_OP_EXT_EXC  = 4'b0111,
    PSCS_OP_EXT_INV  = 4'b1000,
    PSCS_OP_SUBSET_I = 4'b1001,
    PSCS_OP_SUBSET_D = 4'b1010,
    PSCS_OP_CACHE_II = 4'b1011,
    PSCS_OP_CACHE_DW = 4'b1100,
    PSCS_OP_DUPGRADE = 4'b1101
  } pscs_op_t;

  typedef enum logic [0:0] {
    PSCS_SWEEP = 1'b0,
    PSCS_RUN   = 1'b1
  } pscs_mode_t;

  typedef struct packed {
    pscs_op_t                   op;
    logic [`PSCS_VIDX_W-1:0]    vidx;
    logic [`PSCS_TAG_W-1:0]     ptag;
    logic                       way;
    pscs_dstate_t               state;
    logic [`PSCS_AQ_ID_W-1:0]   aq_entry;
  } pscs_req_t;

  typedef struct packed {
    logic                       hit;
    logic                       way;
    pscs_dstate_t               state;
    logic                       inconsistent;
    logic                       upgrade;
    logic                       stall;
  } pscs_rsp_t;

  typedef struct packed {
    logic                       valid;
    logic                       way;
    logic [`PSCS_DSET_W-1:0]    set;
    logic [`PSCS_TAG_W-1:0]     tag;
  } pscs_wb_t;
endpackage

// ---- verification/pscs_cache_sva.sv ----
`timescale 1ns/1ps
`include "pscs_consts.svh"
// ****************
// cache port checks
// ****************
module pscs_cache_sva import pscs_pkg::*; (
  input wire logic                     clk_sys,        // core clock
  input wire logic                     rst_b,          // sync reset
  input wire logic                     ce,             // clock enable
  input wire logic                     req_valid,      // request
  input wire pscs_req_t                req,            // fields
  input wire logic                     req_ready,      // ready
  input wire logic                     rsp_valid,      // answer
  input wire pscs_rsp_t                rsp,            // answer fields
  input wire pscs_wb_t                 wb,             // write-back
  input wire logic                     lock_relaxed,   // policy
  input wire logic                     aq_alloc_valid, // entry in
  input wire logic [`PSCS_AQ_ID_W-1:0] aq_alloc_entry, // its id
  input wire logic                     aq_grad_valid,  // entry out
  input wire logic [`PSCS_AQ_ID_W-1:0] aq_grad_entry   // its id
);
  logic       tk;
  logic [9:0] swp_q;
  logic [9:0] swp_d;
  // take strobe and sweep count; saturates so it never wraps
  assign tk    = req_valid & req_ready & ce;
  assign swp_d = (swp_q == 10'h200) ? swp_q : swp_q + {9'h000, ce};
  always_ff @(posedge clk_sys) begin
    swp_q <= rst_b ? swp_d : 10'h000;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  chk_sweep_len: assert property (req_ready == (swp_q == 10'h200))
    else $error("ready out of step with sweep");
  chk_rsp_after_take: assert property (tk |=> rsp_valid)
    else $error("no answer after take");
  chk_no_spur_rsp: assert property (ce && !tk |=> !rsp_valid)
    else $error("answer without take");
  chk_wb_with_rsp: assert property (wb.valid |-> rsp_valid)
    else $error("write-back without answer");
  chk_wb_set: assert property (wb.valid |-> wb.set == $past(req.vidx[13:5]))
    else $error("write-back set wrong");
  chk_no_wb_ops: assert property (tk && req.op inside {PSCS_OP_EXT_INV, PSCS_OP_DLOAD, PSCS_OP_DSTORE,
    PSCS_OP_IFETCH} |=> !wb.valid)
    else $error("unexpected write-back");
  chk_upgrade_shd: assert property (rsp_valid && rsp.upgrade |-> rsp.hit && rsp.state == PSCS_SHD
    && $past(req.op) == PSCS_OP_DSTORE)
    else $error("upgrade without shared store hit");
  chk_illegal_op: assert property (tk && req.op > PSCS_OP_DUPGRADE |=> rsp == '0 && !wb.valid)
    else $error("illegal opcode answered");
endmodule
bind pscs_cache pscs_cache_sva pscs_cache_sva_i (.clk_sys, .rst_b, .ce, .req_valid, .req, .req_ready,
  .rsp_valid, .rsp, .wb, .lock_relaxed, .aq_alloc_valid, .aq_alloc_entry, .aq_grad_valid, .aq_grad_entry);

// ---- verification/pscs_sec_model.sv ----
`timescale 1ns/1ps
// ****************
// secondary cache side
// ****************
module pscs_sec_model import pscs_pkg::*; (
  input wire logic     clk_sys, // core clock
  input wire logic     rst_b,   // sync reset
  input wire pscs_wb_t wb,      // write-back in
  output int           n_wb     // write-backs taken
);
  // takes every write-back at once; no back-pressure modelled
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      n_wb <= 0;
    end else if (wb.valid) begin
      n_wb <= n_wb + 1;
    end
  end
endmodule

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
module tb_top import pscs_pkg::*; ;
  // ****************
  // bench
  // ****************
  logic        clk_sys = 1'b0;
  logic        rst_b = 1'b0;
  logic        ce = 1'b1;
  logic        req_valid = 1'b0;
  logic        lock_relaxed = 1'b0;
  logic        aq_alloc_valid = 1'b0;
  logic        aq_grad_valid = 1'b0;
  logic [3:0]  aq_alloc_entry = 4'h0;
  logic [3:0]  aq_grad_entry = 4'h0;
  pscs_req_t   req = '0;
  logic        req_ready;
  logic        rsp_valid;
  pscs_rsp_t   rsp;
  pscs_wb_t    wb;
  int          n_wb;
  int          err_count = 0;
  int          total_checks = 0;
  int          exp_wb = 0;
  logic [13:0] v;
  logic [27:0] t;
  logic [3:0]  e;
  pscs_op_t    iops [4] = '{PSCS_OP_EXT_EXC, PSCS_OP_EXT_INV, PSCS_OP_SUBSET_I, PSCS_OP_CACHE_II};
  always #4 clk_sys = ~clk_sys;
  pscs_cache pscs_cache_i (.clk_sys, .rst_b, .ce, .req_valid, .req, .req_ready, .rsp_valid, .rsp, .wb,
    .lock_relaxed, .aq_alloc_valid, .aq_alloc_entry, .aq_grad_valid, .aq_grad_entry);
  pscs_sec_model pscs_sec_model_i (.clk_sys, .rst_b, .wb, .n_wb);
  task automatic cmp(input string n, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x) begin
      err_count++;
      $display("ERROR %s expected %0h seen %0h", n, x, g);
    end
  endtask
  task automatic summarize;
    if (err_count == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  function automatic logic [31:0] er(logic h, logic w, pscs_dstate_t s, logic i, logic u);
    return 32'(pscs_rsp_t'{h, w, s, i, u, 1'b0});
  endfunction
  // address_queue entry in (g=0) or graduating (g=1)
  task automatic aq(input logic g, input logic [3:0] n);
    @(posedge clk_sys);
    aq_alloc_valid <= !g;
    aq_grad_valid <= g;
    aq_alloc_entry <= n;
    aq_grad_entry <= n;
    @(posedge clk_sys);
    aq_alloc_valid <= 1'b0;
    aq_grad_valid <= 1'b0;
  endtask
  // one request; answer sampled after the landing edge
  task automatic go(input pscs_op_t o, input logic [13:0] a, input logic [27:0] g, input logic [3:0] n,
                    input logic xw = 1'b0, input pscs_dstate_t s = PSCS_INV);
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req <= '{o, a, g, 1'b0, s, n};
    @(posedge clk_sys);
    req_valid <= 1'b0;
    #1;
    cmp("rsp_valid", 1, rsp_valid);
    cmp("wb_valid", xw, wb.valid);
    exp_wb += xw;
  endtask
  initial begin
    repeat (5000) @(posedge clk_sys);
    err_count++;
    summarize();
  end
  initial begin
    void'($urandom(32'h0D3F4FBA));
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    for (int i = 0; i < 600 && req_ready !== 1'b1; i++) begin
      @(posedge clk_sys);
      #1;
    end
    cmp("ready", 1, req_ready);
    // data line life: fill, hit, store, subset eviction
    for (int i = 0; i < 8; i++) begin
      e = 4'(i);
      v = {3'(i), 1'b0, 10'($urandom)};
      t = 28'($urandom);
      aq(1'b0, e);
      go(PSCS_OP_DFILL, v, t, e, 1'b0, PSCS_CEX);
      cmp("fill_way", 0, rsp.way);
      go(PSCS_OP_DLOAD, v, t, e);
      cmp("load", er(1, 0, PSCS_CEX, 0, 0), rsp);
      go(PSCS_OP_DLOAD, v, t ^ 28'h1, e);
      cmp("miss", 0, rsp.hit);
      go(PSCS_OP_DSTORE, v, t, e);
      cmp("store", er(1, 0, PSCS_CEX, 0, 0), rsp);
      go(PSCS_OP_DLOAD, v, t, e);
      cmp("dirty", er(1, 0, PSCS_DEX, 1, 0), rsp);
      aq(1'b1, e);
      go(PSCS_OP_SUBSET_D, v, t, e, 1'b1);
      cmp("wb_set", 32'(v[13:5]), 32'(wb.set));
      cmp("wb_tag", t, wb.tag);
      cmp("wb_way", 0, wb.way);
      go(PSCS_OP_DLOAD, v, t, e);
      cmp("gone", 0, rsp.hit);
    end
    // instruction lines under each invalidating event
    for (int k = 0; k < 4; k++) begin
      v = {8'(128 + k), 6'($urandom)};
      t = 28'($urandom);
      go(PSCS_OP_IFILL, v, t, 4'h0);
      cmp("ifill_way", 0, rsp.way);
      go(PSCS_OP_IFETCH, v, t, 4'h0);
      cmp("ihit", 1, rsp.hit);
      go(PSCS_OP_IFETCH, v, t ^ 28'h8, 4'h0);
      cmp("itag", 0, rsp.hit);
      go(iops[k], v, t, 4'h0);
      go(PSCS_OP_IFETCH, v, t, 4'h0);
      cmp("iinv", 0, rsp.hit);
    end
    // shared store needs upgrade; external requests
    aq(1'b0, 4'h8);
    v = {9'h1FF, 5'($urandom)};
    go(PSCS_OP_DFILL, v, t, 4'h8, 1'b0, PSCS_SHD);
    go(PSCS_OP_DSTORE, v, t, 4'h8);
    cmp("upgrade", er(1, 0, PSCS_SHD, 0, 1), rsp);
    go(PSCS_OP_DUPGRADE, v, t, 4'h8, 1'b0, PSCS_DEX);
    go(PSCS_OP_DSTORE, v, t, 4'h8);
    cmp("excl", er(1, 0, PSCS_DEX, 0, 0), rsp);
    go(PSCS_OP_EXT_SHR, v, t, 4'h8, 1'b1);
    go(PSCS_OP_DLOAD, v, t, 4'h8);
    cmp("shared", er(1, 0, PSCS_SHD, 0, 0), rsp);
    go(PSCS_OP_EXT_INV, v, t, 4'h8);
    go(PSCS_OP_DLOAD, v, t, 4'h8);
    cmp("ext_inv", 0, rsp.hit);
    aq(1'b1, 4'h8);
    // line locks, both policies
    v = {9'h1FE, 5'($urandom)};
    aq(1'b0, 4'h1);
    aq(1'b0, 4'h2);
    go(PSCS_OP_DFILL, v, t, 4'h1, 1'b0, PSCS_CEX);
    go(PSCS_OP_DFILL, v, t ^ 28'h10, 4'h1, 1'b0, PSCS_CEX);
    cmp("fill2_way", 1, rsp.way);
    go(PSCS_OP_DLOAD, v, t, 4'h1);
    cmp("lock_a", er(1, 0, PSCS_CEX, 0, 0), rsp);
    go(PSCS_OP_DLOAD, v, t ^ 28'h10, 4'h2);
    cmp("lock_b", 1, rsp.stall);
    @(posedge clk_sys);
    lock_relaxed <= 1'b1;
    go(PSCS_OP_DLOAD, v, t ^ 28'h10, 4'h2);
    cmp("relax", er(1, 1, PSCS_CEX, 0, 0), rsp);
    aq(1'b0, 4'h3);
    go(PSCS_OP_DLOAD, v, t, 4'h3);
    cmp("share", 0, rsp.stall);
    go(PSCS_OP_DFILL, v, t ^ 28'h20, 4'h3, 1'b0, PSCS_CEX);
    cmp("fill_lock", 1, rsp.stall);
    aq(1'b1, 4'h1);
    aq(1'b1, 4'h2);
    aq(1'b1, 4'h3);
    go(PSCS_OP_DFILL, v, t ^ 28'h20, 4'h3, 1'b0, PSCS_CEX);
    cmp("fill_free", 2'b10, {rsp.way, rsp.stall});
    go(PSCS_OP_CACHE_DW, v, t, 4'h0);
    go(PSCS_OP_DLOAD, v, t, 4'h0);
    cmp("cache_dw", 0, rsp.hit);
    go(pscs_op_t'(4'hE), v, t, 4'h0);
    cmp("illegal", 0, rsp);
    // clock enable low: a pending request must not be taken
    @(posedge clk_sys);
    ce <= 1'b0;
    req_valid <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    cmp("frozen", 0, rsp_valid);
    @(posedge clk_sys);
    ce <= 1'b1;
    req_valid <= 1'b0;
    cmp("wb_count", exp_wb, n_wb);
    summarize();
  end
endmodule
